// File: rtl/ata_cfg.svh
// Named constants for the task-file command block and its host controller.
// Assumes a 40 MHz clock and an APB host bus with byte addresses.
`ifndef ATA_CFG_SVH
`define ATA_CFG_SVH

// Opcodes.
`define OP_STBY_IMM 8'h94
`define OP_STBY_IMM_ALT 8'he0
`define OP_XLATE 8'h87
`define OP_WEAR 8'hf5
`define OP_WBUF 8'he8
`define OP_WDMA 8'hca

// Sector geometry: 512 bytes are 256 words of 16 bits.
`define SECT_WORDS 9'h100
`define LAST_WORD 8'hff
`define WORD_SHIFT 8
`define ONE_SECT 9'h001

// Idle timer: the time in ms and the clock rate give the count.
`define CLK_KHZ 40000
`define IDLE_MS 20
`define IDLE_CYC (`IDLE_MS * `CLK_KHZ)

// Host register byte offsets.
`define OFS_CMD 8'h00
`define OFS_ADDR 8'h04
`define OFS_CNT 8'h08
`define OFS_PAT 8'h0c
`define OFS_STAT 8'h10
`define OFS_RLBA 8'h14
`define OFS_RCNT 8'h18

`endif

// File: rtl/ata_pkg.sv
// Types shared by the device and host ends of the task-file link.
// Assumes nothing beyond a SystemVerilog compiler.
package ata_pkg;

   typedef enum logic [2:0] {
      D_IDLE, D_DECODE, D_PIO, D_DMA, D_FLASH, D_END
   } dev_st_t;

   typedef struct packed {
      dev_st_t st;
      logic sleep;
      logic bsy;
      logic drq;
      logic err;
      logic abrt;
      logic intrq;
      logic fl_req;
      logic [7:0] cmd;
      logic [7:0] cnt;
      logic [27:0] lba;
      logic [8:0] left;
      logic [7:0] widx;
      logic [19:0] idle;
      logic [15:0] rdata;
   } dev_state_t;

   typedef enum logic [1:0] {
      H_IDLE, H_ISSUE, H_ARM, H_XFER
   } host_st_t;

   typedef struct packed {
      host_st_t st;
      logic dma;
      logic cmd_wr;
      logic dmack_n;
      logic iowr_n;
      logic [7:0] cmd;
      logic [7:0] cnt;
      logic [27:0] lba;
      logic [15:0] pat;
      logic [16:0] words;
      logic [15:0] wdata;
      logic [31:0] prdata;
   } host_state_t;

endpackage

// File: rtl/ata_link_if.sv
// Link between the host controller and the command block.
// Assumes one clock for both ends; every signal is a plain level.
`timescale 1ns/10ps
interface ata_link_if;
   logic cmd_wr;
   logic [7:0] cmd;
   logic [7:0] tf_cnt;
   logic [27:0] tf_lba;
   logic bsy;
   logic drq;
   logic err;
   logic abrt;
   logic intrq;
   logic [7:0] res_cnt;
   logic [27:0] res_lba;
   logic dmareq;
   logic dmack_n;
   logic iowr_n;
   logic [15:0] wdata;

   modport dev (
      input cmd_wr, cmd, tf_cnt, tf_lba, dmack_n, iowr_n, wdata,
      output bsy, drq, err, abrt, intrq, res_cnt, res_lba, dmareq
   );
   modport host (
      output cmd_wr, cmd, tf_cnt, tf_lba, dmack_n, iowr_n, wdata,
      input bsy, drq, err, abrt, intrq, res_cnt, res_lba, dmareq
   );
endinterface

// File: rtl/ata_cmd_dev.sv
// Command block of the storage card: standby, no-op, buffer and DMA writes.
// Assumes a host end on the link and a flash writer on the user side.
//
// Contract
// RULE1 - Standby immediate: sleep, clear busy, interrupt
// RULE2 - Any new command wakes from sleep
// RULE3 - Translate sector is no-op, count reads zero
// RULE4 - Wear level is no-op, count reads zero
// RULE5 - Write buffer fills sector buffer, no flash
// RULE6 - Write buffer moves 512 bytes by PIO handshake
// RULE7 - DMA write 1 to 256 sectors, zero means 256
// RULE8 - DMA write starts at task-file address
// RULE9 - DMA accept sets busy, then data request
// RULE10 - Request held only while data is accepted
// RULE11 - Host acknowledges only during request when ready
// RULE12 - Host strobes write once per word
// RULE13 - Host sends 512 bytes per sector
// RULE14 - One interrupt at end or on error
// RULE15 - Success leaves address of last sector
// RULE16 - Error stops at the failing sector
// RULE17 - Error leaves address of failing sector
// RULE18 - Host assumes nothing after an error
// RULE19 - Byte mode set aborts DMA write
// RULE20 - Idle timer of 20 ms also enters sleep
// RULE21 - Abort sets error, abort bit, interrupt
`timescale 1ns/10ps
`include "ata_cfg.svh"
module ata_cmd_dev #(
   parameter int IDLE_CYCLES = `IDLE_CYC
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // Link to the host.
   ata_link_if.dev link,
   // Mode strap from the feature logic.
   input wire logic eight_bit_mode,
   // Flash writer.
   output logic fl_req,
   output logic [27:0] fl_lba,
   input wire logic fl_done,
   input wire logic fl_err,
   input wire logic [7:0] buf_raddr,
   output logic [15:0] buf_rdata,
   // State.
   output logic sleeping
);

   ata_pkg::dev_state_t s;
   ata_pkg::dev_state_t n;
   logic [15:0] buf_mem [256];
   logic wr_word;
   logic [19:0] idle_last;

   assign idle_last = 20'(IDLE_CYCLES - 1);

   // A word is taken on any cycle the strobe is low during a PIO data request or a DMA
   // acknowledge; the host keeps one high cycle between strobes, so a level here counts as one word.
   always_comb begin
      wr_word = 1'b0;
      if (!link.iowr_n) begin
         if (s.st == ata_pkg::D_PIO && s.drq && link.dmack_n) begin
            wr_word = 1'b1; // RULE6
         end
         if (s.st == ata_pkg::D_DMA && !link.dmack_n) begin
            wr_word = 1'b1;
         end
      end
   end

   always_comb begin
      n = s;
      n.rdata = buf_mem[buf_raddr];
      if (s.st == ata_pkg::D_IDLE && !s.sleep) begin
         if (s.idle == idle_last) begin
            n.sleep = 1'b1; // RULE20
            n.idle = '0;
         end else begin
            n.idle = s.idle + 20'h00001;
         end
      end else begin
         n.idle = '0;
      end
      unique case (s.st)
         ata_pkg::D_IDLE: begin
            if (link.cmd_wr) begin
               n.sleep = 1'b0; // RULE2
               n.intrq = 1'b0;
               n.err = 1'b0;
               n.abrt = 1'b0;
               n.bsy = 1'b1;
               n.cmd = link.cmd;
               n.cnt = link.tf_cnt;
               n.lba = link.tf_lba; // RULE8
               n.st = ata_pkg::D_DECODE;
            end
         end
         ata_pkg::D_DECODE: begin
            n.bsy = 1'b0;
            n.st = ata_pkg::D_IDLE;
            case (s.cmd)
               `OP_STBY_IMM, `OP_STBY_IMM_ALT: begin
                  n.sleep = 1'b1; // RULE1
                  n.intrq = 1'b1;
               end
               `OP_XLATE: begin
                  n.cnt = '0; // RULE3
                  n.intrq = 1'b1;
               end
               `OP_WEAR: begin
                  n.cnt = '0; // RULE4
                  n.intrq = 1'b1;
               end
               `OP_WBUF: begin
                  n.drq = 1'b1; // RULE5
                  n.widx = '0;
                  n.st = ata_pkg::D_PIO;
               end
               `OP_WDMA: begin
                  if (eight_bit_mode) begin
                     n.err = 1'b1; // RULE19
                     n.abrt = 1'b1;
                     n.intrq = 1'b1;
                  end else begin
                     if (s.cnt == 8'h00) begin
                        n.left = `SECT_WORDS; // RULE7
                     end else begin
                        n.left = {1'b0, s.cnt};
                     end
                     n.widx = '0;
                     n.drq = 1'b1; // RULE9
                     n.st = ata_pkg::D_DMA;
                  end
               end
               default: begin
                  n.err = 1'b1; // RULE21
                  n.abrt = 1'b1;
                  n.intrq = 1'b1;
               end
            endcase
         end
         ata_pkg::D_PIO: begin
            if (wr_word) begin
               n.widx = s.widx + 8'h01;
               if (s.widx == `LAST_WORD) begin
                  n.drq = 1'b0; // RULE6
                  n.bsy = 1'b1;
                  n.st = ata_pkg::D_END;
               end
            end
         end
         ata_pkg::D_END: begin
            n.bsy = 1'b0;
            n.intrq = 1'b1;
            n.st = ata_pkg::D_IDLE;
         end
         ata_pkg::D_DMA: begin
            if (wr_word) begin
               n.widx = s.widx + 8'h01;
               if (s.widx == `LAST_WORD) begin
                  n.fl_req = 1'b1;
                  n.st = ata_pkg::D_FLASH; // RULE10
               end
            end
         end
         ata_pkg::D_FLASH: begin
            if (fl_done) begin
               n.fl_req = 1'b0;
               if (fl_err) begin
                  n.err = 1'b1; // RULE16
                  n.drq = 1'b0;
                  n.intrq = 1'b1; // RULE14
                  n.st = ata_pkg::D_IDLE; // RULE17
               end else if (s.left == `ONE_SECT) begin
                  n.drq = 1'b0;
                  n.cnt = '0;
                  n.intrq = 1'b1; // RULE14
                  n.st = ata_pkg::D_IDLE; // RULE15
               end else begin
                  n.lba = s.lba + 28'h0000001;
                  n.left = s.left - `ONE_SECT;
                  n.cnt = s.cnt - 8'h01;
                  n.widx = '0;
                  n.st = ata_pkg::D_DMA;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // The buffer has no reset; a fresh card holds unknown data anyway.
   always_ff @(posedge clock) begin
      if (wr_word) begin
         buf_mem[s.widx] <= link.wdata;
      end
   end

   assign link.dmareq = (s.st == ata_pkg::D_DMA); // RULE10
   assign link.bsy = s.bsy;
   assign link.drq = s.drq;
   assign link.err = s.err;
   assign link.abrt = s.abrt;
   assign link.intrq = s.intrq;
   assign link.res_cnt = s.cnt;
   assign link.res_lba = s.lba;
   assign fl_req = s.fl_req;
   assign fl_lba = s.lba;
   assign buf_rdata = s.rdata;
   assign sleeping = s.sleep;

endmodule

// File: rtl/ata_host_ctl.sv
// Host controller: APB registers drive commands and data onto the link.
// Assumes the command block on the link and an APB master on the bus.
`timescale 1ns/10ps
`include "ata_cfg.svh"
module ata_host_ctl (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link to the device.
   ata_link_if.host link
);

   ata_pkg::host_state_t s;
   ata_pkg::host_state_t n;
   logic mapped;
   logic wr_acc;
   logic [31:0] rd_mux;

   always_comb begin
      mapped = 1'b1;
      rd_mux = '0;
      case (paddr)
         `OFS_CMD: rd_mux = {24'h000000, s.cmd};
         `OFS_ADDR: rd_mux = {4'h0, s.lba};
         `OFS_CNT: rd_mux = {24'h000000, s.cnt};
         `OFS_PAT: rd_mux = {16'h0000, s.pat};
         `OFS_STAT: rd_mux = {26'h0000000, link.abrt, link.err, link.drq,
                              link.bsy, link.intrq, s.st != ata_pkg::H_IDLE};
         `OFS_RLBA: rd_mux = {4'h0, link.res_lba};
         `OFS_RCNT: rd_mux = {24'h000000, link.res_cnt};
         default: mapped = 1'b0;
      endcase
      wr_acc = psel && penable && pwrite && mapped;
   end

   always_comb begin
      n = s;
      n.cmd_wr = 1'b0;
      n.iowr_n = 1'b1;
      if (psel && !penable) begin
         n.prdata = rd_mux;
      end
      if (wr_acc) begin
         case (paddr)
            `OFS_ADDR: n.lba = pwdata[27:0];
            `OFS_CNT: n.cnt = pwdata[7:0];
            `OFS_PAT: n.pat = pwdata[15:0];
            default: ;
         endcase
      end
      unique case (s.st)
         ata_pkg::H_IDLE: begin
            if (wr_acc && paddr == `OFS_CMD) begin
               n.cmd = pwdata[7:0];
               n.st = ata_pkg::H_ISSUE;
            end
         end
         ata_pkg::H_ISSUE: begin
            n.cmd_wr = 1'b1;
            n.dma = (s.cmd == `OP_WDMA);
            n.words = '0;
            if (s.cmd == `OP_WBUF) begin
               n.words = {8'h00, `SECT_WORDS};
            end
            if (s.cmd == `OP_WDMA) begin
               if (s.cnt == 8'h00) begin
                  n.words = {`SECT_WORDS, 8'h00}; // RULE13
               end else begin
                  n.words = {1'b0, s.cnt, 8'h00};
               end
            end
            n.st = ata_pkg::H_ARM;
         end
         ata_pkg::H_ARM: begin
            n.st = ata_pkg::H_XFER;
         end
         ata_pkg::H_XFER: begin
            if (link.intrq) begin
               n.dmack_n = 1'b1; // RULE18
               n.st = ata_pkg::H_IDLE;
            end else if (s.words == '0 || !s.iowr_n) begin
               // Let go of the acknowledge as soon as the request is gone.
               n.dmack_n = s.dmack_n || !link.dmareq; // RULE11
            end else if (s.dma ? link.dmareq : (link.drq && !link.bsy)) begin
               n.iowr_n = 1'b0; // RULE12
               n.dmack_n = !s.dma; // RULE11
               n.wdata = s.pat;
               n.pat = s.pat + 16'h0001;
               n.words = s.words - 17'h00001;
            end else begin
               n.dmack_n = 1'b1; // RULE11
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
         s.dmack_n <= 1'b1;
         s.iowr_n <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign prdata = s.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign link.cmd_wr = s.cmd_wr;
   assign link.cmd = s.cmd;
   assign link.tf_cnt = s.cnt;
   assign link.tf_lba = s.lba;
   assign link.dmack_n = s.dmack_n;
   assign link.iowr_n = s.iowr_n;
   assign link.wdata = s.wdata;

endmodule

// File: testbench/ata_standby_buffer_write_dma_cmds_chk.sv
// Assertions on the task-file link between host controller and card.
// Assumes one clock domain; placed beside the link interface instance.
`timescale 1ns/10ps
`include "ata_cfg.svh"
module ata_standby_buffer_write_dma_cmds_chk (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // Link signals.
   input wire logic cmd_wr,
   input wire logic [7:0] cmd,
   input wire logic bsy,
   input wire logic drq,
   input wire logic err,
   input wire logic abrt,
   input wire logic intrq,
   input wire logic [7:0] res_cnt,
   input wire logic dmareq,
   input wire logic dmack_n,
   input wire logic iowr_n
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   // A command is only taken while the card is neither busy nor in a transfer.
   logic take;
   assign take = cmd_wr && !bsy && !drq;

   standby_answer_a: assert property (
      take && (cmd == `OP_STBY_IMM || cmd == `OP_STBY_IMM_ALT)
      |-> ##1 bsy ##1 (!bsy && intrq))
      else $error("Standby did not answer with busy then interrupt.");
   nop_count_a: assert property (
      take && (cmd == `OP_XLATE || cmd == `OP_WEAR)
      |-> ##2 (intrq && res_cnt == 8'h00))
      else $error("No-op command left a nonzero count.");
   dma_accept_a: assert property (
      take && cmd == `OP_WDMA
      |-> ##1 bsy ##1 (!bsy && ((drq && dmareq) || (intrq && abrt))))
      else $error("DMA write was not accepted with busy then request.");
   ack_request_a: assert property ($fell(dmack_n) |-> dmareq)
      else $error("Acknowledge raised without a request.");
   ack_release_a: assert property (
      !dmack_n && !dmareq |=> dmack_n)
      else $error("Acknowledge held after the request fell.");
   strobe_pulse_a: assert property (!iowr_n |=> iowr_n)
      else $error("Write strobe held low for more than a cycle.");
   pio_strobe_a: assert property (
      !iowr_n && dmack_n |-> drq && !dmareq)
      else $error("Programmed write strobe outside data request.");
   intr_end_a: assert property (
      $rose(intrq) |-> !bsy && !drq && !dmareq)
      else $error("Interrupt raised while a transfer was open.");
   abort_flags_a: assert property (
      $rose(abrt) |-> err && intrq && !bsy)
      else $error("Abort raised without error and interrupt.");
   intr_hold_a: assert property (intrq && !cmd_wr |=> intrq)
      else $error("Interrupt dropped without a new command.");
   err_stop_a: assert property (err |-> !dmareq)
      else $error("Request still raised after an error.");
endmodule

// File: testbench/ata_standby_buffer_write_dma_cmds_tb_top.sv
// Self-checking bench: APB host controller driving the card over the link.
// Assumes the flash writer is modelled here and answers in one cycle.
`timescale 1ns/10ps
`include "ata_cfg.svh"
module ata_standby_buffer_write_dma_cmds_tb_top;
   logic clock, reset_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, buf_raddr;
   logic [31:0] pwdata, prdata, rd;
   logic eight_bit_mode, fl_req, fl_done, fl_err, fail_en, sleeping, slverr;
   logic [27:0] fl_lba, fail_lba;
   logic [15:0] buf_rdata;
   logic [27:0] fl_seen[$];
   int fail_count, total_checks, words, w0, f0;
   ata_link_if link();
   ata_cmd_dev #(.IDLE_CYCLES(50)) u_ata_cmd_dev (.clock(clock),
      .reset_n(reset_n), .link(link), .eight_bit_mode(eight_bit_mode),
      .fl_req(fl_req), .fl_lba(fl_lba), .fl_done(fl_done), .fl_err(fl_err),
      .buf_raddr(buf_raddr), .buf_rdata(buf_rdata), .sleeping(sleeping));
   ata_host_ctl u_ata_host_ctl (.clock(clock), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link));
   ata_standby_buffer_write_dma_cmds_chk u_chk (.clock(clock),
      .reset_n(reset_n), .cmd_wr(link.cmd_wr), .cmd(link.cmd),
      .bsy(link.bsy), .drq(link.drq), .err(link.err), .abrt(link.abrt),
      .intrq(link.intrq), .res_cnt(link.res_cnt), .dmareq(link.dmareq),
      .dmack_n(link.dmack_n), .iowr_n(link.iowr_n));

   always #12.5 clock = ~clock;

   // Flash writer answers one cycle after a program request.
   always @(posedge clock) begin
      fl_done <= fl_req && !fl_done;
      fl_err <= fl_req && !fl_done && fail_en && fl_lba == fail_lba;
      if (fl_req && !fl_done)
         fl_seen.push_back(fl_lba);
   end

   // Counts every data word the card is entitled to take.
   always @(posedge clock) begin
      if (!link.iowr_n && ((link.drq && link.dmack_n)
         || (link.dmareq && !link.dmack_n)))
         words <= words + 1;
   end

   task automatic complete_run;
      if (fail_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp,
      input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic run_cmd(input logic [7:0] op);
      apb(1'b1, `OFS_CMD, {24'h0, op});
      while (link.bsy !== 1'b1) @(posedge clock);
      while (link.intrq !== 1'b1) @(posedge clock);
   endtask

   task automatic t_reset_idle;
      chk("sleeping", 32'h0, {31'h0, sleeping});
      apb(1'b0, `OFS_STAT, 32'h0);
      chk("stat", 32'h0, rd);
      apb(1'b0, 8'h1c, 32'h0);
      chk("slverr", 32'h1, {31'h0, slverr});
      repeat (60) @(posedge clock);
      chk("idle sleep", 32'h1, {31'h0, sleeping});
   endtask

   task automatic t_standby_nop;
      logic [7:0] ops[4];
      ops = '{`OP_STBY_IMM, `OP_XLATE, `OP_STBY_IMM_ALT, `OP_WEAR};
      for (int i = 0; i < 2; i++) begin
         run_cmd(ops[2*i]);
         chk("sleep", 32'h1, {31'h0, sleeping});
         apb(1'b1, `OFS_CNT, 32'h5);
         run_cmd(ops[2*i+1]);
         chk("wake", 32'h0, {31'h0, sleeping});
         apb(1'b0, `OFS_RCNT, 32'h0);
         chk("nop count", 32'h0, rd);
      end
   endtask

   task automatic t_wbuf;
      f0 = fl_seen.size();
      w0 = words;
      apb(1'b1, `OFS_PAT, 32'h1f00);
      run_cmd(`OP_WBUF);
      chk("wbuf words", 32'd256, words - w0);
      chk("wbuf flash", 32'h0, fl_seen.size() - f0);
      for (int k = 0; k < 256; k += 255) begin
         buf_raddr <= k[7:0];
         repeat (2) @(posedge clock);
         chk("buffer", 32'h1f00 + k, {16'h0, buf_rdata});
      end
   endtask

   task automatic t_dma(input logic [27:0] start, input logic [7:0] cnt,
      input logic fail, input int nsec, input logic [7:0] rcnt);
      f0 = fl_seen.size();
      w0 = words;
      fail_en = fail;
      fail_lba = start + 28'h2;
      apb(1'b1, `OFS_ADDR, {4'h0, start});
      apb(1'b1, `OFS_CNT, {24'h0, cnt});
      run_cmd(`OP_WDMA);
      chk("sectors", nsec, fl_seen.size() - f0);
      chk("first lba", {4'h0, start}, {4'h0, fl_seen[f0]});
      if (!fail)
         chk("words", nsec * 256, words - w0);
      apb(1'b0, `OFS_RLBA, 32'h0);
      chk("res lba", {4'h0, start} + nsec - 1, rd);
      apb(1'b0, `OFS_RCNT, 32'h0);
      chk("res cnt", {24'h0, rcnt}, rd);
      apb(1'b0, `OFS_STAT, 32'h0);
      chk("err", {31'h0, fail}, {31'h0, rd[4]});
   endtask

   task automatic t_byte_abort;
      w0 = words;
      eight_bit_mode <= 1'b1;
      run_cmd(`OP_WDMA);
      apb(1'b0, `OFS_STAT, 32'h0);
      chk("abort", 32'h3, {30'h0, rd[5:4]});
      chk("no words", 32'h0, words - w0);
      eight_bit_mode <= 1'b0;
      // An opcode the block does not know must be refused the same way.
      w0 = words;
      run_cmd(8'h00);
      apb(1'b0, `OFS_STAT, 32'h0);
      chk("unknown abort", 32'h3, {30'h0, rd[5:4]});
      chk("unknown words", 32'h0, words - w0);
   endtask

   initial begin
      clock = 1'b0;
      reset_n = 1'b0;
      {psel, penable, pwrite, eight_bit_mode} = '0;
      {paddr, pwdata, buf_raddr, fail_lba, fail_en} = '0;
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      t_reset_idle();
      t_standby_nop();
      t_wbuf();
      t_dma(28'h0123450, 8'h02, 1'b0, 2, 8'h00);
      t_byte_abort();
      // An error leaves the host side undefined, so it runs last.
      t_dma(28'h00000f0, 8'h00, 1'b1, 3, 8'hfe);
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      complete_run();
   end
endmodule
